// ### src/cfc_frame_codec.sv
// Frame codec, CRC and block memory of the contactless tag
`timescale 1ns/10ps
// Behaviour
// - Each byte travels as a ten-bit character, LSB first.
// - Character: start bit 0, eight data bits LSB first, stop bit 1.
// - Any receive error: no error answer, no execution.
// - One ETU lasts 9.44 us, 106 kbit/s both ways.
// - Request SOF: ten ETUs low, then two to three ETUs high.
// - Request EOF: ten ETUs low then a rising edge ends the frame.
// - Answer SOF: ten ETUs zero then two ETUs one.
// - Answer EOF: ten ETUs zero then two ETUs one.
// - Answer bits are BPSK on an 847.5 kHz subcarrier.
// - No modulation for at least 128 subcarrier periods after a frame.
// - Then 128 subcarrier periods of reference phase for sync.
// - First phase change after sync is the start of the answer SOF.
// - CRC is 16-bit Type B, preset to all ones.
// - Two CRC bytes before EOF cover all bytes after SOF.
// - Bad request CRC: frame dropped, no answer.
// - CRC goes low byte first, each byte LSB first.
// - Sixteen 16-bit blocks; blocks 0 to 3 hold fixed identifier.
// - Blocks 4 to 14 user area; block 15 bits 3:0 give select id; lock bits sit in their own register.
// - Lock inhibits writes to blocks 4 to 15 in pairs.
// - Protection status of blocks 4 to 15 is reported.
module cfc_frame_codec
  import cfc_pkg::*;
#(
  parameter logic [63:0] ID_WORDS = 64'h0123_4567_89AB_CDEF // Arbitrary
) (
  input  wire logic        clk_sys_in,        // 25 MHz clock
  input  wire logic        rst_n_in,          // Sync reset, active low
  input  wire logic        rx_line_in,        // Demodulated request level
  output logic             load_mod_out,      // Load modulation switch
  output logic             tx_busy_out,       // Answer on the air
  output logic [7:0]       rx_byte_out,       // Received byte
  output logic             rx_byte_valid_out, // Byte strobe
  output logic             rx_frame_ok_out,   // Good frame end
  output logic             rx_frame_err_out,  // Bad frame end
  input  wire logic [7:0]  tx_data_in,        // Answer byte
  input  wire logic        tx_valid_in,       // Answer byte present
  output logic             tx_ready_out,      // Answer byte taken
  input  wire logic [3:0]  mem_addr_in,       // Block address
  input  wire logic [15:0] mem_wdata_in,      // Block write data
  input  wire logic        mem_write_in,      // Block write strobe
  output logic [15:0]      mem_rdata_out,     // Block read data
  input  wire logic        lock_set_in,       // Lock strobe
  input  wire logic [5:0]  lock_mask_in,      // Pairs to lock
  output logic [5:0]       prot_status_out,   // Locked pairs
  output logic [3:0]       tag_select_identifier_out // Block 15 id
);

  if (ETU_CYC < 16 || ETU_CYC > 240) begin : g_chk
    $error("ETU cycle count outside supported range");
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // Receive line synchroniser
  logic rx_s1, rx_s2, rx_d;
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_d  <= 1'b1;
    end else begin
      rx_s1 <= rx_line_in;
      rx_s2 <= rx_s1;
      rx_d  <= rx_s2;
    end
  end
  wire fall = rx_d & ~rx_s2;
  wire rise = ~rx_d & rx_s2;

  cfc_rx_state_t rx_st;
  logic [11:0]   rx_cnt;
  logic [3:0]    rx_idx;
  logic [9:0]    rx_sh;
  logic [15:0]   rx_crc;
  logic [1:0]    rx_nb;
  wire  rx_hi_ok = rx_cnt >= HI_MIN_CYC && rx_cnt <= HI_MAX_CYC;
  wire  rx_lo_ok = rx_cnt >= LOW_MIN_CYC && rx_cnt <= LOW_MAX_CYC;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      rx_st             <= RX_IDLE;
      rx_cnt            <= 12'h000;
      rx_idx            <= 4'h0;
      rx_sh             <= 10'h000;
      rx_crc            <= CRC_PRESET;
      rx_nb             <= 2'h0;
      rx_byte_out       <= 8'h00;
      rx_byte_valid_out <= 1'b0;
      rx_frame_ok_out   <= 1'b0;
      rx_frame_err_out  <= 1'b0;
    end else begin
      rx_byte_valid_out <= 1'b0;
      rx_frame_ok_out   <= 1'b0;
      rx_frame_err_out  <= 1'b0;
      if (rx_cnt != CNT_MAX) rx_cnt <= rx_cnt + 12'h001;
      case (rx_st)
        RX_IDLE: if (fall) begin
          rx_st  <= RX_SOFL;
          rx_cnt <= 12'h000;
        end
        RX_SOFL: if (rise) begin
          rx_cnt <= 12'h000;
          rx_st  <= rx_lo_ok ? RX_SOFH : RX_IDLE;
        end else if (rx_cnt > LOW_MAX_CYC) begin
          rx_st <= RX_IDLE;
        end
        // SOF high phase, then first start bit
        RX_SOFH: if (fall) begin
          rx_cnt <= 12'h000;
          rx_idx <= 4'h0;
          rx_crc <= CRC_PRESET;
          rx_nb  <= 2'h0;
          rx_st  <= rx_hi_ok ? RX_CHAR : RX_IDLE;
        end else if (rx_cnt > HI_MAX_CYC) begin
          rx_st <= RX_IDLE;
        end
        RX_CHAR: begin
          if (rx_cnt == BIT_END_CYC) begin
            rx_cnt <= 12'h000;
            rx_idx <= rx_idx + 4'h1;
          end
          if (rx_cnt == HALF_CYC) begin
            rx_sh <= {rx_s2, rx_sh[9:1]};
            if (rx_idx == 4'(CHAR_BITS - 1)) begin
              rx_cnt <= 12'h000;
              // Start 0 and stop 1 framing
              if (!rx_sh[1] && rx_s2) begin
                rx_byte_out       <= rx_sh[9:2];
                rx_byte_valid_out <= 1'b1;
                rx_crc <= crc_byte(rx_crc, rx_sh[9:2]);
                if (rx_nb != 2'h3) rx_nb <= rx_nb + 2'h1;
                rx_st <= RX_GAP;
              end else if (rx_sh[9:1] == 9'h000 && !rx_s2) begin
                rx_st <= RX_EOF;
              end else begin
                rx_frame_err_out <= 1'b1;
                rx_st            <= RX_IDLE;
              end
            end
          end
        end
        RX_GAP: if (fall) begin
          rx_cnt <= 12'h000;
          rx_idx <= 4'h0;
          rx_st  <= RX_CHAR;
        end else if (rx_cnt > GAP_MAX_CYC) begin
          rx_frame_err_out <= 1'b1;
          rx_st            <= RX_IDLE;
        end
        // EOF closes on the rising edge
        RX_EOF: if (rise) begin
          rx_st <= RX_IDLE;
          // Residue check over data and CRC bytes
          if (rx_nb == 2'h3 && rx_crc == CRC_RESIDUE) begin
            rx_frame_ok_out <= 1'b1;
          end else begin
            rx_frame_err_out <= 1'b1;
          end
        end else if (rx_cnt > EOF_MAX_CYC) begin
          rx_frame_err_out <= 1'b1;
          rx_st            <= RX_IDLE;
        end
        default: rx_st <= RX_IDLE;
      endcase
    end
  end

  // Subcarrier: 16 half periods per ETU, fractional step
  logic [7:0] sc_cnt;
  logic [7:0] sc_acc;
  logic       sc;
  wire        etu_tick = sc_cnt == 8'(ETU_CYC - 1);
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sc_cnt <= 8'h00;
      sc_acc <= 8'h00;
      sc     <= 1'b0;
    end else begin
      sc_cnt <= etu_tick ? 8'h00 : sc_cnt + 8'h01;
      if (sc_acc + 8'h10 >= 8'(ETU_CYC)) begin
        sc_acc <= sc_acc + 8'h10 - 8'(ETU_CYC);
        sc     <= ~sc;
      end else begin
        sc_acc <= sc_acc + 8'h10;
      end
    end
  end

  cfc_tx_state_t tx_st;
  cfc_src_t      tx_src, next_src;
  logic [4:0]    tx_seg;
  logic [3:0]    tx_idx;
  logic [9:0]    tx_sh, next_sh;
  logic [15:0]   tx_crc, next_crc;
  logic          next_take, next_end, tx_bit;
  logic [4:0]    guard;
  wire  tx_done  = tx_st == TX_EOF && etu_tick && tx_seg == 5'(MARK_ETU - 1);
  wire  tx_load  = etu_tick && ((tx_st == TX_SOF && tx_seg == 5'(MARK_ETU - 1))
                   || (tx_st == TX_CHAR && tx_idx == 4'(CHAR_BITS - 1)));

  // Guard time restarts after every frame
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || rx_st != RX_IDLE || tx_done) begin
      guard <= 5'h00;
    end else if (etu_tick && guard != 5'(GUARD_ETU)) begin
      guard <= guard + 5'h01;
    end
  end

  // Next character: data, then CRC low, CRC high, then EOF
  always_comb begin
    next_sh   = tx_sh;
    next_crc  = tx_crc;
    next_src  = tx_src;
    next_take = 1'b0;
    next_end  = 1'b0;
    if (tx_src == SRC_DATA && tx_valid_in) begin
      next_sh   = {1'b1, tx_data_in, 1'b0};
      next_crc  = crc_byte(tx_crc, tx_data_in);
      next_take = 1'b1;
    end else if (tx_src == SRC_DATA) begin
      next_sh  = {1'b1, ~tx_crc[7:0], 1'b0};
      next_src = SRC_LO;
    end else if (tx_src == SRC_LO) begin
      next_sh  = {1'b1, ~tx_crc[15:8], 1'b0};
      next_src = SRC_HI;
    end else begin
      next_end = 1'b1;
    end
  end

  always_comb begin
    case (tx_st)
      TX_SOF, TX_EOF: tx_bit = tx_seg >= 5'(MARK_LOW_ETU);
      TX_CHAR:        tx_bit = tx_sh[0];
      default:        tx_bit = 1'b1;
    endcase
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      tx_st        <= TX_IDLE;
      tx_src       <= SRC_DATA;
      tx_seg       <= 5'h00;
      tx_idx       <= 4'h0;
      tx_sh        <= 10'h3FF;
      tx_crc       <= CRC_PRESET;
      tx_ready_out <= 1'b0;
    end else begin
      tx_ready_out <= 1'b0;
      if (tx_load) begin
        tx_sh        <= next_sh;
        tx_crc       <= next_crc;
        tx_src       <= next_src;
        tx_ready_out <= next_take;
        tx_idx       <= 4'h0;
        tx_seg       <= 5'h00;
        tx_st        <= next_end ? TX_EOF : TX_CHAR;
      end else if (etu_tick) begin
        case (tx_st)
          TX_IDLE: if (tx_valid_in && guard == 5'(GUARD_ETU)
                       && rx_st == RX_IDLE) begin
            tx_st  <= TX_SYNC;
            tx_seg <= 5'h00;
          end
          TX_SYNC: if (tx_seg == 5'(SYNC_ETU - 1)) begin
            tx_st  <= TX_SOF;
            tx_seg <= 5'h00;
            tx_src <= SRC_DATA;
            tx_crc <= CRC_PRESET;
          end else begin
            tx_seg <= tx_seg + 5'h01;
          end
          TX_CHAR: begin
            tx_sh  <= {1'b1, tx_sh[9:1]};
            tx_idx <= tx_idx + 4'h1;
          end
          TX_SOF, TX_EOF: begin
            tx_seg <= tx_seg + 5'h01;
            if (tx_done) tx_st <= TX_IDLE;
          end
          default: tx_st <= TX_IDLE;
        endcase
      end
    end
  end

  // Logic one keeps reference phase, zero inverts it
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      load_mod_out <= 1'b0;
      tx_busy_out  <= 1'b0;
    end else begin
      load_mod_out <= (tx_st != TX_IDLE) & (sc ^ ~tx_bit);
      tx_busy_out  <= tx_st != TX_IDLE;
    end
  end

  // Block memory; identifier blocks are constants, not storage
  logic [15:0] blk [ID_BLOCKS:NUM_BLOCKS-1];
  logic [5:0]  lock;
  wire  [2:0]  pair = 3'((mem_addr_in - 4'(ID_BLOCKS)) >> 1);
  wire         user = mem_addr_in >= 4'(ID_BLOCKS);
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      lock <= 6'h00;
    end else if (lock_set_in) begin
      lock <= lock | lock_mask_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      for (int i = ID_BLOCKS; i < NUM_BLOCKS; i++) blk[i] <= BLOCK_RESET;
    end else if (mem_write_in && user && !lock[pair]) begin
      blk[mem_addr_in] <= mem_wdata_in;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      mem_rdata_out             <= 16'h0000;
      prot_status_out           <= 6'h00;
      tag_select_identifier_out <= 4'h0;
    end else begin
      mem_rdata_out <= user ? blk[mem_addr_in]
                            : ID_WORDS[mem_addr_in[1:0]*16 +: 16];
      prot_status_out           <= lock;
      tag_select_identifier_out <= blk[NUM_BLOCKS-1][3:0];
    end
  end

  a_guard_quiet: assert property (
    (tx_st == TX_IDLE) |=> !load_mod_out)
    else $error("modulation outside an answer");
  a_answer_after_guard: assert property (
    $rose(tx_st == TX_SYNC) |-> $past(guard) == 5'(GUARD_ETU))
    else $error("answer began before guard time");
  a_sync_length: assert property (
    tx_st == TX_SYNC |-> tx_seg < 5'(SYNC_ETU) && tx_bit)
    else $error("sync phase too long or modulated");
  a_mark_zeros: assert property (
    (tx_st == TX_SOF || tx_st == TX_EOF) && tx_seg < 5'(MARK_LOW_ETU)
    |-> !tx_bit)
    else $error("frame mark low part wrong");
  a_start_stop: assert property (
    tx_st == TX_CHAR |-> (tx_idx != 4'h0 || !tx_bit)
    && (tx_idx != 4'h9 || tx_bit))
    else $error("answer start or stop bit wrong");
  a_bpsk_phase: assert property (
    tx_st != TX_IDLE |=> load_mod_out == ($past(sc) ^ ~$past(tx_bit)))
    else $error("subcarrier phase does not follow bit");
  a_ok_needs_crc: assert property (
    rx_frame_ok_out |-> $past(rx_crc) == CRC_RESIDUE && !rx_frame_err_out)
    else $error("frame accepted with bad CRC");
  a_err_no_answer: assert property (
    rx_frame_err_out |=> tx_st == TX_IDLE && !rx_frame_ok_out)
    else $error("error frame followed by activity");
  a_lock_sticky: assert property (
    (lock & $past(lock)) == $past(lock))
    else $error("lock bit cleared");
  a_locked_write: assert property (
    mem_write_in && user && lock[pair] |=> blk[$past(mem_addr_in)]
    == $past(blk[mem_addr_in]))
    else $error("write reached a locked block");
  a_id_read_only: assert property (
    !user |=> mem_rdata_out == ID_WORDS[$past(mem_addr_in[1:0])*16 +: 16])
    else $error("identifier block changed");

  c_frame_ok:  cover property (rx_frame_ok_out);
  c_frame_err: cover property (rx_frame_err_out);
  c_answer:    cover property (tx_done);
  c_locked:    cover property (mem_write_in && user && lock[pair]);
endmodule : cfc_frame_codec

// ### src/cfc_pkg.sv
// Constants, types and CRC helper for the tag frame codec
package cfc_pkg;
  localparam int unsigned CLK_KHZ     = 25000;
  // Elementary time unit, ns
  localparam int unsigned ETU_NS      = 9440;
  localparam int unsigned ETU_CYC     = ETU_NS * CLK_KHZ / 1000000;
  localparam int unsigned SC_PER_ETU  = 8;
  localparam int unsigned GUARD_SC    = 128;
  localparam int unsigned SYNC_SC     = 128;
  localparam int unsigned GUARD_ETU   = GUARD_SC / SC_PER_ETU;
  localparam int unsigned SYNC_ETU    = SYNC_SC / SC_PER_ETU;
  localparam int unsigned MARK_LOW_ETU = 10;
  localparam int unsigned MARK_ETU    = 12;
  localparam int unsigned SOF_HI_MIN_ETU = 2;
  localparam int unsigned SOF_HI_MAX_ETU = 3;
  localparam int unsigned CHAR_BITS   = 10;
  localparam int unsigned GAP_MAX_ETU = 16;
  localparam logic [11:0] HALF_CYC    = 12'(ETU_CYC / 2);
  localparam logic [11:0] BIT_END_CYC = 12'(ETU_CYC - 1);
  localparam logic [11:0] LOW_MIN_CYC = 12'(MARK_LOW_ETU * ETU_CYC - ETU_CYC / 2);
  localparam logic [11:0] LOW_MAX_CYC = 12'(MARK_LOW_ETU * ETU_CYC + ETU_CYC / 2);
  localparam logic [11:0] HI_MIN_CYC  = 12'(SOF_HI_MIN_ETU * ETU_CYC - ETU_CYC / 2);
  localparam logic [11:0] HI_MAX_CYC  = 12'(SOF_HI_MAX_ETU * ETU_CYC + ETU_CYC / 2);
  localparam logic [11:0] GAP_MAX_CYC = 12'(GAP_MAX_ETU * ETU_CYC);
  localparam logic [11:0] EOF_MAX_CYC = 12'(ETU_CYC);
  localparam logic [11:0] CNT_MAX     = 12'hFFF;
  localparam logic [15:0] CRC_PRESET  = 16'hFFFF;
  localparam logic [15:0] CRC_POLY    = 16'h8408;
  localparam logic [15:0] CRC_RESIDUE = 16'hF0B8;
  localparam int unsigned NUM_BLOCKS  = 16;
  localparam int unsigned ID_BLOCKS   = 4;
  localparam int unsigned LOCK_PAIRS  = 6;
  localparam logic [15:0] BLOCK_RESET = 16'h0000;

  typedef enum logic [2:0] {
    RX_IDLE, RX_SOFL, RX_SOFH, RX_CHAR, RX_GAP, RX_EOF
  } cfc_rx_state_t;
  typedef enum logic [2:0] {
    TX_IDLE, TX_SYNC, TX_SOF, TX_CHAR, TX_EOF
  } cfc_tx_state_t;
  typedef enum logic [1:0] {SRC_DATA, SRC_LO, SRC_HI} cfc_src_t;

  // Reflected CRC, one byte, LSB first
  function automatic logic [15:0] crc_byte(input logic [15:0] crc,
                                           input logic [7:0]  data);
    logic [15:0] c;
    c = crc ^ {8'h00, data};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_byte
endpackage : cfc_pkg

// ### test/cfc_reader_model.sv
// Reader-side request driver for the tag frame codec bench
`timescale 1ns/10ps
module cfc_reader_model
  import cfc_pkg::*;
(
  input  wire logic clk_sys_in,  // System clock
  output logic      rx_line_out  // Demodulated request level
);
  // Demodulator idles high between frames
  initial rx_line_out = 1'b1;

  // Whole ETUs, changed just after an edge
  task automatic hold(input logic v, input int etu);
    @(posedge clk_sys_in);
    #1 rx_line_out = v;
    repeat (etu * ETU_CYC - 1) @(posedge clk_sys_in);
  endtask : hold

  // Ten ETUs low, then the high part
  task automatic send_sof(input int hi_etu);
    hold(1'b0, MARK_LOW_ETU);
    hold(1'b1, hi_etu);
  endtask : send_sof

  // Start bit, data LSB first, stop bit
  task automatic send_char(input logic [7:0] b, input logic stop);
    hold(1'b0, 1);
    for (int i = 0; i < 8; i++) hold(b[i], 1);
    hold(stop, 1);
  endtask : send_char

  // Ten ETUs low, one rise, idle after
  task automatic send_eof();
    hold(1'b0, MARK_LOW_ETU);
    @(posedge clk_sys_in);
    #1 rx_line_out = 1'b1;
  endtask : send_eof
endmodule : cfc_reader_model

// ### test/test_contactless_tag_frame_codec.sv
// Self-checking bench for the tag frame codec
`timescale 1ns/10ps
module test_contactless_tag_frame_codec
  import cfc_pkg::*;
;
  // Arbitrary identifier content
  localparam logic [63:0] ID_VAL = 64'h5A3C_9E17_0B62_D4F8;
  logic        clk_sys_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic        rx_line, load_mod, busy, rx_vld, rx_ok, rx_err, lm_q;
  logic        tx_valid, tx_ready, mem_write, lock_set;
  logic [7:0]  rx_byte, tx_data, lfsr = 8'h35;
  logic [3:0]  mem_addr, sel_id;
  logic [15:0] mem_wdata, mem_rdata, rd;
  logic [15:0] m[16];
  logic [5:0]  lock_mask, prot;
  logic [7:0]  fr[$];
  logic [15:0] exp_q[$];
  int          error_cnt, num_checks, cyc, last_e, t0, t_busy, t_ok, run;

  always #20 clk_sys_in = ~clk_sys_in;

  cfc_reader_model u_rdr (.clk_sys_in(clk_sys_in), .rx_line_out(rx_line));
  cfc_frame_codec #(.ID_WORDS(ID_VAL)) u_dut (
    .clk_sys_in               (clk_sys_in),
    .rst_n_in                 (rst_n_in),
    .rx_line_in               (rx_line),
    .load_mod_out             (load_mod),
    .tx_busy_out              (busy),
    .rx_byte_out              (rx_byte),
    .rx_byte_valid_out        (rx_vld),
    .rx_frame_ok_out          (rx_ok),
    .rx_frame_err_out         (rx_err),
    .tx_data_in               (tx_data),
    .tx_valid_in              (tx_valid),
    .tx_ready_out             (tx_ready),
    .mem_addr_in              (mem_addr),
    .mem_wdata_in             (mem_wdata),
    .mem_write_in             (mem_write),
    .mem_rdata_out            (mem_rdata),
    .lock_set_in              (lock_set),
    .lock_mask_in             (lock_mask),
    .prot_status_out          (prot),
    .tag_select_identifier_out(sel_id)
  );

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic pop_cmp(input logic [15:0] got);
    if (exp_q.size() == 0) check(got, 16'hFFFF);
    else check(got, exp_q.pop_front());
  endtask : pop_cmp

  function automatic logic [7:0] rnd();
    lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
    return lfsr;
  endfunction : rnd

  task automatic add_crc(input logic bad);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (fr[i]) for (int k = 0; k < 8; k++)
      c = (c[0] ^ fr[i][k]) ? ((c >> 1) ^ 16'h8408) : (c >> 1);
    c = ~c ^ {15'h0000, bad};
    fr.push_back(c[7:0]);
    fr.push_back(c[15:8]);
  endtask : add_crc

  // Watches outputs and retires the oldest note per event
  always @(posedge clk_sys_in) begin
    cyc++;
    lm_q <= load_mod;
    if (rx_vld) pop_cmp({8'h10, rx_byte});
    if (rx_ok) pop_cmp(16'h2000);
    if (rx_err) pop_cmp(16'h3000);
    if (rx_ok) t_ok = cyc;
    if (load_mod && !busy) check(16'h0001, 16'h0000);
    if (busy !== 1'b1) begin
      last_e = cyc;
      t0 = 0;
      t_busy = cyc;
    end else if (load_mod !== lm_q) begin
      run = cyc - last_e;
      last_e = cyc;
      // Doubled half period marks a phase flip
      if (run > 22) begin
        if (t0 == 0) begin
          t0 = cyc;
          pop_cmp({4'h6, 12'(t_busy - t_ok >= GUARD_ETU * ETU_CYC - 8)});
          pop_cmp({4'h5, 12'((cyc - t_busy + ETU_CYC / 2) / ETU_CYC)});
        end
        pop_cmp({4'h4, 12'((cyc - t0 + ETU_CYC / 2) / ETU_CYC)});
      end else if (t0 != 0) begin
        check({15'h0000, run >= 13 && run <= 16}, 16'h0001);
      end
    end
  end

  // Fault 0 good, 1 bad CRC, 2 bad stop bit, 3 ignored opening
  task automatic request(input int hi, input int fault);
    fr = {rnd()};
    add_crc(fault == 1);
    if (fault < 2) foreach (fr[i]) exp_q.push_back({8'h10, fr[i]});
    if (fault < 3) exp_q.push_back(fault == 0 ? 16'h2000 : 16'h3000);
    u_rdr.send_sof(hi);
    foreach (fr[i]) if (fault != 2 || i == 0)
      u_rdr.send_char(fr[i], fault != 2);
    u_rdr.send_eof();
    repeat (10) @(posedge clk_sys_in);
    #1;
  endtask : request

  task automatic answer(input int n);
    logic bits[$];
    int   w;
    fr = {};
    repeat (n) fr.push_back(rnd());
    add_crc(1'b0);
    repeat (10) bits.push_back(1'b0);
    repeat (2) bits.push_back(1'b1);
    foreach (fr[i]) begin
      bits.push_back(1'b0);
      for (int k = 0; k < 8; k++) bits.push_back(fr[i][k]);
      bits.push_back(1'b1);
    end
    repeat (10) bits.push_back(1'b0);
    repeat (2) bits.push_back(1'b1);
    // Guard, sync length, then SOF flip
    exp_q.push_back(16'h6001);
    exp_q.push_back({4'h5, 12'(SYNC_ETU)});
    foreach (bits[k]) if (k == 0 || bits[k] != bits[k - 1])
      exp_q.push_back({4'h4, 12'(k)});
    tx_data = fr[0];
    tx_valid = 1'b1;
    for (int i = 0; i < n; i++) begin
      w = 0;
      do begin
        @(posedge clk_sys_in);
        w++;
      end while (tx_ready !== 1'b1 && w < 12000);
      #1;
      if (i + 1 < n) tx_data = fr[i + 1];
      else tx_valid = 1'b0;
    end
    w = 0;
    while (busy !== 1'b0 && w < 12000) begin
      @(posedge clk_sys_in);
      w++;
    end
    repeat (4 * ETU_CYC) @(posedge clk_sys_in);
    #1;
  endtask : answer

  task automatic mem_wr(input logic [3:0] a, input logic [15:0] d);
    mem_addr = a;
    mem_wdata = d;
    mem_write = 1'b1;
    @(posedge clk_sys_in);
    #1 mem_write = 1'b0;
    // Strobe stays low for one edge between writes
    @(posedge clk_sys_in);
    #1;
  endtask : mem_wr

  task automatic verify_all();
    for (int a = 0; a < 16; a++) begin
      mem_addr = 4'(a);
      @(posedge clk_sys_in);
      #1 check(mem_rdata, m[a]);
    end
    check({12'h000, sel_id}, {12'h000, m[15][3:0]});
  endtask : verify_all

  task automatic mem_test();
    int p;
    for (int a = 0; a < 16; a++) begin
      m[a] = {rnd(), rnd()};
      mem_wr(4'(a), m[a]);
      if (a < 4) m[a] = ID_VAL[16 * a +: 16];
    end
    verify_all();
    p = rnd() % 6;
    lock_mask = 6'(1 << p);
    lock_set = 1'b1;
    @(posedge clk_sys_in);
    #1 lock_set = 1'b0;
    @(posedge clk_sys_in);
    #1 check({10'h000, prot}, {10'h000, 6'(1 << p)});
    // Locked pair keeps old data, others take new
    for (int a = 4; a < 16; a++) begin
      mem_wr(4'(a), ~m[a]);
      if ((a - 4) / 2 != p) m[a] = ~m[a];
    end
    verify_all();
  endtask : mem_test

  // Mid-run reset: user blocks, locks and answer path clear
  task automatic reset_test();
    rst_n_in = 1'b0;
    repeat (3) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    for (int a = 4; a < 16; a++) m[a] = 16'h0000;
    check({14'h0000, busy, load_mod}, 16'h0000);
    check({10'h000, prot}, 16'h0000);
    verify_all();
  endtask : reset_test

  task automatic end_test(input string s);
    check(16'(exp_q.size()), 16'h0000);
    $display("test %s done", s);
  endtask : end_test

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize

  initial begin
    tx_valid = 1'b0;
    tx_data = rnd();
    mem_write = 1'b0;
    mem_addr = 4'h0;
    mem_wdata = {rnd(), rnd()};
    lock_set = 1'b0;
    lock_mask = 6'(rnd());
    repeat (12) @(posedge clk_sys_in);
    #1 rst_n_in = 1'b1;
    mem_test();
    end_test("memory");
    reset_test();
    end_test("reset");
    request(2, 0);
    request(3, 0);
    end_test("good requests");
    request(2, 1);
    request(2, 2);
    request(5, 3);
    end_test("bad requests");
    repeat (5 * ETU_CYC) @(posedge clk_sys_in);
    #1;
    request(3, 0);
    answer(2);
    end_test("answer");
    summarize();
  end

  initial begin
    repeat (100000) @(posedge clk_sys_in);
    error_cnt++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end
endmodule : test_contactless_tag_frame_codec
